// file: efic_host.sv
// frame source for the host or the stored program
// assumes: the bench calls send() once per frame
module efic_host (
	// clock
	input wire logic clk,
	// frame
	output logic CMD_VALID = 1'b0,
	output logic CMD_DIRECT = 1'b0,
	output logic [7:0] CMD_ADDR = 8'h00,
	output logic [7:0] CMD_OPCODE = 8'h00,
	output logic [7:0] CMD_TYPE = 8'h00,
	output logic [7:0] CMD_BANK = 8'h00,
	output logic [31:0] CMD_VALUE = 32'h0000_0000,
	output logic [7:0] CMD_CSUM = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic send(input logic d, input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v,
		input logic bad);
		logic [7:0] s;
		s = 8'h01 + op + ty + 8'h5A + v[31:24] + v[23:16] + v[15:8] + v[7:0] + {7'h00, bad};
		@(posedge clk);
		CMD_VALID <= 1'b1;
		CMD_DIRECT <= d;
		CMD_ADDR <= 8'h01;
		CMD_OPCODE <= op;
		CMD_TYPE <= ty;
		CMD_BANK <= 8'h5A;
		CMD_VALUE <= v;
		CMD_CSUM <= s;
		@(posedge clk);
		// released type, value and checksum show garbage; address, opcode, bank and direct keep the old frame
		CMD_VALID <= 1'b0;
		CMD_TYPE <= ~ty;
		CMD_VALUE <= ~v;
		CMD_CSUM <= ~s;
	endtask : send
endmodule : efic_host

// file: efic_pkg.sv
// constants for the error-flag and interrupt command block
// assumes: one clock, frames already assembled into fields by the frame receiver
package efic_pkg;

	// ==================================================
	// widths
	localparam int IRQ_CNT = 32;
	localparam int FLAG_CNT = 5;
	localparam int PC_W = 16;
	localparam int COND_W = 8;
	localparam logic [7:0] IRQ_LIMIT = 8'h20;

	// ==================================================
	// opcodes and the global interrupt number
	localparam logic [7:0] OP_ENABLE = 8'd25;
	localparam logic [7:0] OP_DISABLE = 8'd26;
	localparam logic [7:0] OP_FLAG_CLEAR = 8'd36;
	localparam logic [7:0] OP_VECTOR = 8'd37;
	localparam logic [7:0] OP_RETURN = 8'd38;
	localparam logic [7:0] IRQ_GLOBAL = 8'hFF;

	// ==================================================
	// flag-clear type codes and flag bit positions
	localparam logic [7:0] CLR_ALL = 8'h00;
	localparam logic [7:0] CLR_LAST = 8'h05;
	localparam int FLAG_TIMEOUT = 0;
	localparam int FLAG_ALARM = 1;
	localparam int FLAG_DEVIATION = 2;
	localparam int FLAG_POSITION = 3;
	localparam int FLAG_SHUTDOWN = 4;

	// ==================================================
	// reply status codes
	localparam logic [7:0] STAT_OK = 8'd100;
	localparam logic [7:0] STAT_BAD_CSUM = 8'd1;
	localparam logic [7:0] STAT_BAD_CMD = 8'd2;
	localparam logic [7:0] STAT_BAD_TYPE = 8'd3;

	// ==================================================
	// register map (byte addresses)
	localparam logic [7:0] REG_EVT_STATUS = 8'h00;
	localparam logic [7:0] REG_EVT_CLEAR = 8'h04;
	localparam logic [7:0] REG_EVT_ENABLE = 8'h08;
	localparam logic [7:0] REG_CORE_STATE = 8'h0C;
	localparam logic [7:0] REG_SRC_ENABLE = 8'h10;
	localparam logic [7:0] REG_PEND = 8'h14;

	// event bits
	localparam int EVT_W = 4;
	localparam int EVT_FLAG_RAISED = 0;
	localparam int EVT_ENTERED = 1;
	localparam int EVT_RETURNED = 2;
	localparam int EVT_REJECTED = 3;

	// core state register fields
	localparam int CORE_GLOBAL_BIT = 8;
	localparam int CORE_HANDLER_BIT = 9;

	// reset values
	localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;

	typedef enum logic [0:0] {
		EFIC_RUN = 1'b0,
		EFIC_HANDLER = 1'b1
	} efic_state_t;

endpackage : efic_pkg

// file: efic_top.sv
// error-flag clear and interrupt command execution for the program sequencer
// assumes: frame fields arrive in one cycle on CMD_*, sequencer context on SEQ_*,
// flag and interrupt source events are single-cycle pulses on REF_CLK
//
// Notes on behaviour
// - opcode 36 clears flags chosen by type
// - type 0 all, 1..5 single flags
// - opcode 25 enables the numbered interrupt
// - enable with number 255 sets global processing
// - opcode 26 disables the numbered interrupt
// - disable with number 255 clears global processing
// - opcode 37 stores value as handler address
// - redefining a vector overwrites the old address
// - opcode 38 ends handler, normal flow resumes
// - return restores accumulator, X, flags, counter
module efic_top (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// decoded instruction frame
	input wire logic CMD_VALID,
	input wire logic CMD_DIRECT,
	input wire logic [7:0] CMD_ADDR,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CMD_TYPE,
	input wire logic [7:0] CMD_BANK,
	input wire logic [31:0] CMD_VALUE,
	input wire logic [7:0] CMD_CSUM,
	// direct-mode reply
	output logic RPL_VALID,
	output logic [7:0] RPL_STATUS,
	output logic [7:0] RPL_OPCODE,
	output logic [31:0] RPL_VALUE,
	// sequencer context
	input wire logic SEQ_BOUNDARY,
	input wire logic [31:0] SEQ_ACCU,
	input wire logic [31:0] SEQ_XREG,
	input wire logic [efic_pkg::COND_W-1:0] SEQ_COND,
	input wire logic [efic_pkg::PC_W-1:0] SEQ_PC,
	// jump into a handler
	output logic JUMP_VALID,
	output logic [efic_pkg::PC_W-1:0] JUMP_PC,
	// context restore on return
	output logic RESTORE_VALID,
	output logic [31:0] RESTORE_ACCU,
	output logic [31:0] RESTORE_XREG,
	output logic [efic_pkg::COND_W-1:0] RESTORE_COND,
	output logic [efic_pkg::PC_W-1:0] RESTORE_PC,
	// events and flags
	input wire logic [efic_pkg::FLAG_CNT-1:0] FLAG_SET,
	input wire logic [efic_pkg::IRQ_CNT-1:0] IRQ_SRC,
	output logic [efic_pkg::FLAG_CNT-1:0] ERR_FLAGS,
	output logic GLOBAL_IE,
	output logic IN_HANDLER,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic IRQ
);

	// ==================================================
	// helpers
	function automatic logic [7:0] efic_csum(input logic [7:0] a, input logic [7:0] o, input logic [7:0] t,
		input logic [7:0] b, input logic [31:0] v);
		return a + o + t + b + v[31:24] + v[23:16] + v[15:8] + v[7:0];
	endfunction : efic_csum

	function automatic logic [efic_pkg::FLAG_CNT-1:0] efic_clr_mask(input logic [7:0] t);
		logic [efic_pkg::FLAG_CNT-1:0] m;
		m = '0;
		if (t == efic_pkg::CLR_ALL)
			m = '1;
		else if (t <= efic_pkg::CLR_LAST)
			m[3'(t - 8'h01)] = 1'b1;
		return m;
	endfunction : efic_clr_mask

	// ==================================================
	// state
	efic_pkg::efic_state_t st_q, st_d;
	logic [efic_pkg::FLAG_CNT-1:0] flags_q, flags_d;
	logic gie_q, gie_d;
	logic [efic_pkg::IRQ_CNT-1:0] ien_q, ien_d;
	logic [efic_pkg::IRQ_CNT-1:0] pend_q, pend_d;
	logic [efic_pkg::IRQ_CNT-1:0] take_oh;
	logic [efic_pkg::PC_W-1:0] vec_q [efic_pkg::IRQ_CNT];
	logic vec_we;
	logic [4:0] vec_idx;
	logic [31:0] ctx_acc_q, ctx_acc_d, ctx_x_q, ctx_x_d;
	logic [efic_pkg::COND_W-1:0] ctx_cond_q, ctx_cond_d;
	logic [efic_pkg::PC_W-1:0] ctx_pc_q, ctx_pc_d;
	logic [efic_pkg::EVT_W-1:0] evt_q, evt_d, evt_en_q, evt_en_d, evt;
	logic rpl_valid_d, jump_valid_d, restore_valid_d, irq_d;
	logic [7:0] rpl_status_d;
	logic [efic_pkg::PC_W-1:0] jump_pc_d;
	logic [31:0] rdata_d;

	// decode
	logic ours, csum_ok, misplaced, bad_type, exec, take;
	logic [4:0] take_idx;

	// pending latches: a new request beats the clear of a taken one
	genvar gi;
	generate
		for (gi = 0; gi < efic_pkg::IRQ_CNT; gi++)
		begin : g_pend
			assign pend_d[gi] = IRQ_SRC[gi] | (pend_q[gi] & ~take_oh[gi]);
		end
	endgenerate

	// ==================================================
	// next state
	always_comb
	begin
		ours = (CMD_OPCODE == efic_pkg::OP_FLAG_CLEAR) || (CMD_OPCODE == efic_pkg::OP_ENABLE)
			|| (CMD_OPCODE == efic_pkg::OP_DISABLE) || (CMD_OPCODE == efic_pkg::OP_VECTOR)
			|| (CMD_OPCODE == efic_pkg::OP_RETURN);
		// stored programs carry no checksum byte, only host frames are checked
		csum_ok = !CMD_DIRECT || (CMD_CSUM == efic_csum(CMD_ADDR, CMD_OPCODE, CMD_TYPE, CMD_BANK, CMD_VALUE));
		misplaced = CMD_DIRECT && ((CMD_OPCODE == efic_pkg::OP_VECTOR) || (CMD_OPCODE == efic_pkg::OP_RETURN));
		bad_type = (CMD_OPCODE == efic_pkg::OP_FLAG_CLEAR) && (CMD_TYPE > efic_pkg::CLR_LAST);
		exec = CMD_VALID && ours && csum_ok && !misplaced && !bad_type;

		st_d = st_q;
		gie_d = gie_q;
		ien_d = ien_q;
		ctx_acc_d = ctx_acc_q;
		ctx_x_d = ctx_x_q;
		ctx_cond_d = ctx_cond_q;
		ctx_pc_d = ctx_pc_q;
		vec_we = 1'b0;
		vec_idx = CMD_TYPE[4:0];
		restore_valid_d = 1'b0;
		jump_valid_d = 1'b0;
		jump_pc_d = '0;
		take_oh = '0;
		take_idx = '0;
		evt = '0;

		// value and motor/bank fields are ignored; a raise in the same cycle beats the clear
		flags_d = (flags_q & ~((exec && CMD_OPCODE == efic_pkg::OP_FLAG_CLEAR) ? efic_clr_mask(CMD_TYPE) : '0))
			| FLAG_SET;
		if (exec)
		begin
			unique case (CMD_OPCODE)
				efic_pkg::OP_ENABLE:
				begin
					if (CMD_TYPE == efic_pkg::IRQ_GLOBAL)
						gie_d = 1'b1;
					else if (CMD_TYPE < efic_pkg::IRQ_LIMIT)
						ien_d[CMD_TYPE[4:0]] = 1'b1;
				end
				efic_pkg::OP_DISABLE:
				begin
					if (CMD_TYPE == efic_pkg::IRQ_GLOBAL)
						gie_d = 1'b0;
					else if (CMD_TYPE < efic_pkg::IRQ_LIMIT)
						ien_d[CMD_TYPE[4:0]] = 1'b0;
				end
				efic_pkg::OP_VECTOR:
					vec_we = CMD_TYPE < efic_pkg::IRQ_LIMIT;
				efic_pkg::OP_RETURN:
				begin
					// a return outside a handler has nothing to restore
					if (st_q == efic_pkg::EFIC_HANDLER)
					begin
						restore_valid_d = 1'b1;
						st_d = efic_pkg::EFIC_RUN;
						evt[efic_pkg::EVT_RETURNED] = 1'b1;
					end
				end
				default:
				begin
				end
			endcase
		end

		// lowest-numbered enabled pending source wins; no nesting, no entry while a command runs
		take = !CMD_VALID && SEQ_BOUNDARY && gie_q && (st_q == efic_pkg::EFIC_RUN) && |(pend_q & ien_q);
		for (int i = efic_pkg::IRQ_CNT - 1; i >= 0; i--)
		begin
			if (pend_q[i] && ien_q[i])
				take_idx = 5'(i);
		end
		if (take)
		begin
			take_oh[take_idx] = 1'b1;
			ctx_acc_d = SEQ_ACCU;
			ctx_x_d = SEQ_XREG;
			ctx_cond_d = SEQ_COND;
			ctx_pc_d = SEQ_PC;
			jump_valid_d = 1'b1;
			jump_pc_d = vec_q[take_idx];
			st_d = efic_pkg::EFIC_HANDLER;
			evt[efic_pkg::EVT_ENTERED] = 1'b1;
		end

		// direct-mode reply, value carries no meaning
		rpl_valid_d = CMD_VALID && CMD_DIRECT && ours;
		if (!csum_ok)
			rpl_status_d = efic_pkg::STAT_BAD_CSUM;
		else if (misplaced)
			rpl_status_d = efic_pkg::STAT_BAD_CMD;
		else if (bad_type)
			rpl_status_d = efic_pkg::STAT_BAD_TYPE;
		else
			rpl_status_d = efic_pkg::STAT_OK;

		evt[efic_pkg::EVT_FLAG_RAISED] = |(FLAG_SET & ~flags_q);
		evt[efic_pkg::EVT_REJECTED] = CMD_VALID && ours && !exec;

		// register port: event set beats a clear written in the same cycle
		evt_en_d = evt_en_q;
		if (REG_WR && REG_ADDR == efic_pkg::REG_EVT_ENABLE)
			evt_en_d = REG_WDATA[efic_pkg::EVT_W-1:0];
		evt_d = (evt_q & ~((REG_WR && REG_ADDR == efic_pkg::REG_EVT_CLEAR) ? REG_WDATA[efic_pkg::EVT_W-1:0] : '0))
			| evt;
		irq_d = |(evt_d & evt_en_d);

		rdata_d = '0;
		if (REG_RD)
		begin
			unique case (REG_ADDR)
				efic_pkg::REG_EVT_STATUS: rdata_d[efic_pkg::EVT_W-1:0] = evt_q;
				efic_pkg::REG_EVT_ENABLE: rdata_d[efic_pkg::EVT_W-1:0] = evt_en_q;
				efic_pkg::REG_CORE_STATE:
				begin
					rdata_d[efic_pkg::FLAG_CNT-1:0] = flags_q;
					rdata_d[efic_pkg::CORE_GLOBAL_BIT] = gie_q;
					rdata_d[efic_pkg::CORE_HANDLER_BIT] = (st_q == efic_pkg::EFIC_HANDLER);
				end
				efic_pkg::REG_SRC_ENABLE: rdata_d = ien_q;
				efic_pkg::REG_PEND: rdata_d = pend_q;
				default: rdata_d = '0;
			endcase
		end
	end

	// ==================================================
	// registers
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			st_q <= efic_pkg::EFIC_RUN;
			flags_q <= '0;
			gie_q <= 1'b0;
			ien_q <= efic_pkg::MASK_RESET;
			pend_q <= efic_pkg::MASK_RESET;
			for (int i = 0; i < efic_pkg::IRQ_CNT; i++)
				vec_q[i] <= '0;
			ctx_acc_q <= '0;
			ctx_x_q <= '0;
			ctx_cond_q <= '0;
			ctx_pc_q <= '0;
			evt_q <= efic_pkg::EVT_RESET;
			evt_en_q <= efic_pkg::EVT_RESET;
			RPL_VALID <= 1'b0;
			RPL_STATUS <= '0;
			RPL_OPCODE <= '0;
			RPL_VALUE <= '0;
			JUMP_VALID <= 1'b0;
			JUMP_PC <= '0;
			RESTORE_VALID <= 1'b0;
			RESTORE_ACCU <= '0;
			RESTORE_XREG <= '0;
			RESTORE_COND <= '0;
			RESTORE_PC <= '0;
			ERR_FLAGS <= '0;
			GLOBAL_IE <= 1'b0;
			IN_HANDLER <= 1'b0;
			REG_RDATA <= '0;
			IRQ <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			flags_q <= flags_d;
			gie_q <= gie_d;
			ien_q <= ien_d;
			pend_q <= pend_d;
			if (vec_we)
				vec_q[vec_idx] <= CMD_VALUE[efic_pkg::PC_W-1:0];
			ctx_acc_q <= ctx_acc_d;
			ctx_x_q <= ctx_x_d;
			ctx_cond_q <= ctx_cond_d;
			ctx_pc_q <= ctx_pc_d;
			evt_q <= evt_d;
			evt_en_q <= evt_en_d;
			RPL_VALID <= rpl_valid_d;
			RPL_STATUS <= rpl_status_d;
			RPL_OPCODE <= CMD_OPCODE;
			RPL_VALUE <= '0;
			JUMP_VALID <= jump_valid_d;
			JUMP_PC <= jump_pc_d;
			RESTORE_VALID <= restore_valid_d;
			RESTORE_ACCU <= ctx_acc_q;
			RESTORE_XREG <= ctx_x_q;
			RESTORE_COND <= ctx_cond_q;
			RESTORE_PC <= ctx_pc_q;
			ERR_FLAGS <= flags_d;
			GLOBAL_IE <= gie_d;
			IN_HANDLER <= (st_d == efic_pkg::EFIC_HANDLER);
			REG_RDATA <= rdata_d;
			IRQ <= irq_d;
		end
	end

endmodule : efic_top

// file: efic_top_assertions.sv
// checker on the ports of efic_top
// assumes: one clock domain, bound at the foot of this file
module efic_chk (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// frame and reply
	input wire logic CMD_VALID,
	input wire logic CMD_DIRECT,
	input wire logic [7:0] CMD_ADDR,
	input wire logic [7:0] CMD_OPCODE,
	input wire logic [7:0] CMD_TYPE,
	input wire logic [7:0] CMD_BANK,
	input wire logic [31:0] CMD_VALUE,
	input wire logic [7:0] CMD_CSUM,
	input wire logic RPL_VALID,
	input wire logic [7:0] RPL_STATUS,
	// state
	input wire logic [4:0] FLAG_SET,
	input wire logic [4:0] ERR_FLAGS,
	input wire logic GLOBAL_IE,
	input wire logic IN_HANDLER,
	input wire logic JUMP_VALID,
	input wire logic RESTORE_VALID,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] sum;
	logic sum_ok;
	logic go;
	assign sum = CMD_ADDR + CMD_OPCODE + CMD_TYPE + CMD_BANK + CMD_VALUE[31:24] + CMD_VALUE[23:16]
		+ CMD_VALUE[15:8] + CMD_VALUE[7:0];
	assign sum_ok = sum == CMD_CSUM;
	// stored-program frames carry no checked sum
	assign go = CMD_VALID && (!CMD_DIRECT || sum_ok);
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!ARST_N);
	a_clear_all: assert property (go && CMD_OPCODE == 8'd36 && CMD_TYPE == 8'd0
		&& FLAG_SET == 5'h00 |=> ERR_FLAGS == 5'h00) else $error("flags not cleared");
	a_reply_ok: assert property (CMD_VALID && CMD_DIRECT && sum_ok
		&& CMD_OPCODE inside {8'd25, 8'd26} |=> RPL_VALID && RPL_STATUS == 8'd100) else $error("no ok reply");
	a_reply_cause: assert property (RPL_VALID |-> $past(CMD_VALID) && $past(CMD_DIRECT))
		else $error("stray reply");
	a_global_on: assert property (go && CMD_OPCODE == 8'd25 && CMD_TYPE == 8'hFF |=> GLOBAL_IE)
		else $error("global enable missed");
	a_global_off: assert property (go && CMD_OPCODE == 8'd26 && CMD_TYPE == 8'hFF |=> !GLOBAL_IE)
		else $error("global disable missed");
	a_vector_direct: assert property (CMD_VALID && CMD_DIRECT && sum_ok && CMD_OPCODE == 8'd37
		|=> RPL_STATUS == 8'd2) else $error("direct vector accepted");
	a_entry_cause: assert property (JUMP_VALID |-> IN_HANDLER && $past(GLOBAL_IE)
		&& !$past(IN_HANDLER) && !$past(CMD_VALID)) else $error("bad handler entry");
	a_return_ends: assert property ($fell(IN_HANDLER) |-> RESTORE_VALID)
		else $error("handler left without restore");
	a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0000_0000)
		else $error("read data outside read");
endmodule : efic_chk

bind efic_top efic_chk chk_u (.*);

// file: tb_top.sv
// self-checking bench for efic_top
// assumes: efic_pkg, efic_host and the checker compiled first
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK = 1'b0;
	logic ARST_N = 1'b0;
	logic CMD_VALID, CMD_DIRECT, RPL_VALID, JUMP_VALID, RESTORE_VALID, GLOBAL_IE, IN_HANDLER, IRQ;
	logic [7:0] CMD_ADDR, CMD_OPCODE, CMD_TYPE, CMD_BANK, CMD_CSUM, RPL_STATUS, RPL_OPCODE, RESTORE_COND;
	logic [31:0] CMD_VALUE, RPL_VALUE, RESTORE_ACCU, RESTORE_XREG, REG_RDATA;
	logic [15:0] JUMP_PC, RESTORE_PC;
	logic [4:0] ERR_FLAGS;
	logic SEQ_BOUNDARY = 1'b1;
	logic [31:0] SEQ_ACCU = 32'h1111_2222;
	logic [31:0] SEQ_XREG = 32'h3333_4444;
	logic [7:0] SEQ_COND = 8'h5C;
	logic [15:0] SEQ_PC = 16'h0ABC;
	logic [4:0] FLAG_SET = 5'h00;
	logic [31:0] IRQ_SRC = 32'h0000_0000;
	logic [7:0] REG_ADDR = 8'h00;
	logic [31:0] REG_WDATA = 32'h0000_0000;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	int errors = 0;
	int checks = 0;
	always #2.5 REF_CLK = ~REF_CLK;
	efic_top dut_u (.*);
	efic_host h_u (.clk(REF_CLK), .*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask : w
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic rd_n);
		@(posedge REF_CLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= rd_n;
		REG_RD <= !rd_n;
		@(posedge REF_CLK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1;
	endtask : wr
	task automatic pulse(input logic [4:0] f, input logic [31:0] s);
		@(posedge REF_CLK);
		FLAG_SET <= f;
		IRQ_SRC <= s;
		@(posedge REF_CLK);
		FLAG_SET <= 5'h00;
		IRQ_SRC <= 32'h0000_0000;
	endtask : pulse
	task automatic cmd(input logic d, input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v,
		input logic bad, input logic [7:0] st);
		h_u.send(d, op, ty, v, bad);
		#1;
		chk(RPL_VALID, d);
		if (d)
			chk({RPL_STATUS, RPL_OPCODE, 8'h00} | RPL_VALUE, {st, op, 8'h00});
	endtask : cmd
	task automatic print_verdict();
		if (errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict
	initial
	begin
		w(8);
		ARST_N <= 1'b1;
		w(2);
		chk({GLOBAL_IE, IN_HANDLER, ERR_FLAGS, IRQ}, 0);
		wr(8'h40, 0, 0);
		chk(REG_RDATA, 0);
		for (int t = 1; t <= 5; t++)
		begin
			pulse(5'h1F, 0);
			cmd(1, 8'd36, t[7:0], 32'hFFFF_FFFF, 0, 8'd100);
			chk(ERR_FLAGS, 5'h1F & ~(5'h01 << (t - 1)));
		end
		pulse(5'h1F, 0);
		cmd(1, 8'd36, 8'd6, 0, 0, 8'd3);
		cmd(1, 8'd36, 8'd0, 0, 1, 8'd1);
		chk(ERR_FLAGS, 5'h1F);
		cmd(0, 8'd36, 8'd0, 0, 0, 0);
		chk(ERR_FLAGS, 5'h00);
		// sticky flag event drives the interrupt line through enable
		wr(8'h08, 1, 1);
		w(2);
		chk(IRQ, 1);
		wr(8'h08, 0, 1);
		w(2);
		chk(IRQ, 0);
		wr(8'h08, 1, 1);
		wr(8'h04, 1, 1);
		w(2);
		chk(IRQ, 0);
		cmd(0, 8'd37, 8'd3, 32'h0000_0050, 0, 0);
		cmd(0, 8'd37, 8'd3, 32'h0000_1234, 0, 0);
		cmd(1, 8'd37, 8'd3, 32'h0000_0077, 0, 8'd2);
		cmd(1, 8'd25, 8'd3, 0, 0, 8'd100);
		cmd(1, 8'd25, 8'hFF, 0, 0, 8'd100);
		wr(8'h10, 0, 0);
		chk(REG_RDATA, 32'h0000_0008);
		wr(8'h0C, 0, 0);
		chk(REG_RDATA, 32'h0000_0100);
		pulse(0, 32'h0000_0008);
		w(1);
		chk({JUMP_VALID, IN_HANDLER, JUMP_PC}, {2'b11, 16'h1234});
		@(posedge REF_CLK);
		SEQ_ACCU <= 0;
		SEQ_XREG <= 0;
		SEQ_COND <= 0;
		SEQ_PC <= 0;
		cmd(0, 8'd38, 8'hFF, 0, 0, 0);
		chk({RESTORE_VALID, IN_HANDLER, RESTORE_COND, RESTORE_PC}, {2'b10, 8'h5C, 16'h0ABC});
		chk(RESTORE_ACCU, 32'h1111_2222);
		chk(RESTORE_XREG, 32'h3333_4444);
		cmd(1, 8'd26, 8'd3, 0, 0, 8'd100);
		cmd(1, 8'd26, 8'hFF, 0, 0, 8'd100);
		chk(GLOBAL_IE, 0);
		cmd(1, 8'd25, 8'hFF, 0, 0, 8'd100);
		pulse(0, 32'h0000_0008);
		w(4);
		chk(IN_HANDLER, 0);
		// the source stays latched while its enable is off
		wr(8'h14, 0, 0);
		chk(REG_RDATA, 32'h0000_0008);
		cmd(1, 8'd25, 8'd3, 0, 0, 8'd100);
		w(3);
		chk(IN_HANDLER, 1);
		cmd(1, 8'd38, 8'hFF, 0, 0, 8'd2);
		chk(IN_HANDLER, 1);
		// entered, returned and refused events are sticky
		wr(8'h00, 0, 0);
		chk(REG_RDATA, 32'h0000_000E);
		print_verdict();
	end
	initial
	begin
		#20000;
		errors++;
		print_verdict();
	end
endmodule : tb_top
